// file: hw/sls_pkg.sv
// Purpose: constants and types of the line-side serial ports
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes:   line pins are sampled; edges are found in the mclk domain
// What this block does
// RULE_01 - capture primary data on primary clock rise
// RULE_02 - capture redundant data on its own clock
// RULE_03 - two full receive ports, primary and redundant
// RULE_04 - control register selects transmit reference clock source
// RULE_05 - partner supplies 622.08 MHz reference when selected
// RULE_06 - primary transmit data changes on forwarded clock rise
// RULE_07 - redundant transmit data changes on its clock rise
// RULE_08 - separate primary and redundant transmit ports
// RULE_09 - mode pin: toggle switch output or move streams
// RULE_10 - same outbound stream on both transmit ports
package sls_pkg;

  // ==========================================================
  // register map
  localparam logic [15:0] REG_LINE_CTRL2_ADDR = 16'h0131;
  localparam logic [7:0]  REG_LINE_CTRL2_RST  = 8'h00;
  localparam int          BIT_TX_REF_SEL      = 0;
  localparam int          BIT_SWITCH_CMD      = 1;
  localparam int          BIT_ACTIVE_REDUND   = 2;
  localparam int          BIT_MODE_INTERNAL   = 3;
  localparam logic [7:0]  REG_UNMAPPED_READ   = 8'h00;

  // ==========================================================
  // timing
  localparam real         TX_REF_FREQ_MHZ     = 622.08;
  localparam int          INT_TX_DIV          = 4;
  localparam logic [1:0]  INT_TX_DIV_LAST     = 2'(INT_TX_DIV - 1);
  localparam int          NUM_RX_PORTS        = 2;
  localparam int          PORT_PRIMARY        = 0;
  localparam int          PORT_REDUNDANT      = 1;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic bit_value;
    logic valid;
  } sls_rx_bit_t;

  typedef struct packed {
    logic data_pos;
    logic data_neg;
    logic clk_pos;
    logic clk_neg;
  } sls_tx_pins_t;

endpackage : sls_pkg

// file: hw/sls_line_ports.sv
// Purpose: primary/redundant receive and transmit line ports
// Assumes: line clocks far slower than mclk (oversampled)
// Notes:   receive capture and reference-clock transmit launch use mclk edge detection; internal launch uses a divider
`timescale 1ns/1ps
`default_nettype none
module sls_line_ports
(
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 rx_primary_clock_pos,
  input  wire logic                 rx_primary_clock_neg,
  input  wire logic                 rx_primary_data_pos,
  input  wire logic                 rx_primary_data_neg,
  input  wire logic                 rx_redundant_clock_pos,
  input  wire logic                 rx_redundant_clock_neg,
  input  wire logic                 rx_redundant_data_pos,
  input  wire logic                 rx_redundant_data_neg,
  input  wire logic                 tx_reference_clock_pos,
  input  wire logic                 tx_reference_clock_neg,
  output logic                      tx_primary_data_pos,
  output logic                      tx_primary_data_neg,
  output logic                      tx_primary_fwd_clock_pos,
  output logic                      tx_primary_fwd_clock_neg,
  output logic                      tx_redundant_data_pos,
  output logic                      tx_redundant_data_neg,
  output logic                      tx_redundant_fwd_clock_pos,
  output logic                      tx_redundant_fwd_clock_neg,
  input  wire logic                 protection_internal_select,
  output logic                      protection_switch_out,
  input  wire logic [15:0]          reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata,
  input  wire logic                 tx_line_bit,
  output logic                      tx_bit_taken,
  output sls_pkg::sls_rx_bit_t      rx_primary_bit,
  output sls_pkg::sls_rx_bit_t      rx_redundant_bit,
  output sls_pkg::sls_rx_bit_t      rx_line_bit
);

  // ==========================================================
  // receive ports: sync, edge find, capture
  logic [sls_pkg::NUM_RX_PORTS-1:0] rx_clk_pos_w;
  logic [sls_pkg::NUM_RX_PORTS-1:0] rx_clk_neg_w;
  logic [sls_pkg::NUM_RX_PORTS-1:0] rx_dat_pos_w;
  logic [sls_pkg::NUM_RX_PORTS-1:0] rx_dat_neg_w;
  sls_pkg::sls_rx_bit_t             rx_cap_ff [sls_pkg::NUM_RX_PORTS];

  assign rx_clk_pos_w = {rx_redundant_clock_pos, rx_primary_clock_pos};
  assign rx_clk_neg_w = {rx_redundant_clock_neg, rx_primary_clock_neg};
  assign rx_dat_pos_w = {rx_redundant_data_pos, rx_primary_data_pos};
  assign rx_dat_neg_w = {rx_redundant_data_neg, rx_primary_data_neg};

  // each port captures only on rises of its own line clock, found in the mclk domain, never the other's
  genvar p;
  generate
    for (p = 0; p < sls_pkg::NUM_RX_PORTS; p = p + 1)
    begin : g_rx
      logic [3:0] meta_ff;
      logic [3:0] sync_ff;
      logic       clk_prev_ff;
      wire        clk_level = sync_ff[0] & ~sync_ff[1];
      wire        clk_rise  = clk_level & ~clk_prev_ff;
      wire        dat_level = sync_ff[2] & ~sync_ff[3];

      always_ff @(posedge mclk)
      begin
        if (!rst_n)
        begin
          meta_ff     <= 4'h0;
          sync_ff     <= 4'h0;
          clk_prev_ff <= 1'b0;
          rx_cap_ff[p] <= '0;
        end
        else
        begin
          meta_ff     <= {rx_dat_neg_w[p], rx_dat_pos_w[p],
                          rx_clk_neg_w[p], rx_clk_pos_w[p]};
          sync_ff     <= meta_ff;
          clk_prev_ff <= clk_level;
          // pos leg rising is neg leg falling: same instant
          rx_cap_ff[p].valid <= clk_rise; // RULE_01 RULE_02 RULE_03
          if (clk_rise)
          begin
            rx_cap_ff[p].bit_value <= dat_level; // RULE_01 RULE_02
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // control register and protection switching
  logic [1:0] mode_meta_ff;
  logic       tx_ref_sel_ff;
  logic       active_redund_ff;
  logic       switch_out_ff;
  logic [7:0] rdata_ff;
  sls_pkg::sls_rx_bit_t line_ff;

  wire ctrl_hit   = reg_addr == sls_pkg::REG_LINE_CTRL2_ADDR;
  wire ctrl_wr    = reg_wr & ctrl_hit;
  wire switch_req = ctrl_wr & reg_wdata[sls_pkg::BIT_SWITCH_CMD];
  wire mode_int   = mode_meta_ff[1];
  wire [7:0] ctrl_view = {4'h0, mode_int, active_redund_ff, 1'b0, tx_ref_sel_ff};
  wire [7:0] nxt_rdata = ctrl_hit ? ctrl_view : sls_pkg::REG_UNMAPPED_READ;
  wire sls_pkg::sls_rx_bit_t nxt_line =
    active_redund_ff ? rx_cap_ff[sls_pkg::PORT_REDUNDANT]
                     : rx_cap_ff[sls_pkg::PORT_PRIMARY];

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mode_meta_ff     <= 2'h0;
      tx_ref_sel_ff    <= sls_pkg::REG_LINE_CTRL2_RST[sls_pkg::BIT_TX_REF_SEL];
      active_redund_ff <= 1'b0;
      switch_out_ff    <= 1'b0;
      rdata_ff         <= 8'h00;
      line_ff          <= '0;
    end
    else
    begin
      mode_meta_ff <= {mode_meta_ff[0], protection_internal_select};
      if (ctrl_wr)
      begin
        tx_ref_sel_ff <= reg_wdata[sls_pkg::BIT_TX_REF_SEL]; // RULE_04
      end
      // external mode: toggle the pin; internal: swap streams
      if (switch_req && !mode_int)
      begin
        switch_out_ff <= ~switch_out_ff; // RULE_09
      end
      if (switch_req && mode_int)
      begin
        active_redund_ff <= ~active_redund_ff; // RULE_09
      end
      if (reg_rd)
      begin
        rdata_ff <= nxt_rdata;
      end
      line_ff <= nxt_line; // RULE_09
    end
  end

  // ==========================================================
  // transmit timing: reference clock edges or internal divider
  logic [1:0]          ref_meta_ff;
  logic                ref_prev_ff;
  logic [1:0]          div_ff;
  logic                fwd_ff;
  logic                taken_ff;
  sls_pkg::sls_tx_pins_t tx_ff;

  // 622.08 MHz cannot be oversampled here; bench drives it slower
  wire ref_level = ref_meta_ff[1];
  wire ref_rise  = ref_level & ~ref_prev_ff;
  wire div_tick  = div_ff == sls_pkg::INT_TX_DIV_LAST;
  wire tx_tick   = tx_ref_sel_ff ? ref_rise : div_tick; // RULE_04 RULE_05
  wire launch    = tx_tick & ~fwd_ff;
  wire [1:0] nxt_div = div_tick ? 2'h0 : div_ff + 2'h1;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ref_meta_ff <= 2'h0;
      ref_prev_ff <= 1'b0;
      div_ff      <= 2'h0;
      fwd_ff      <= 1'b0;
      taken_ff    <= 1'b0;
      tx_ff       <= 4'h5;
    end
    else
    begin
      ref_meta_ff <= {ref_meta_ff[0], tx_reference_clock_pos & ~tx_reference_clock_neg};
      ref_prev_ff <= ref_level;
      div_ff      <= nxt_div;
      taken_ff    <= launch;
      if (tx_tick)
      begin
        fwd_ff        <= ~fwd_ff;
        tx_ff.clk_pos <= ~fwd_ff;
        tx_ff.clk_neg <= fwd_ff;
      end
      // data moves together with the forwarded clock rise
      if (launch)
      begin
        tx_ff.data_pos <= tx_line_bit; // RULE_06 RULE_07
        tx_ff.data_neg <= ~tx_line_bit; // RULE_06 RULE_07
      end
    end
  end

  // ==========================================================
  // outputs
  assign tx_primary_data_pos        = tx_ff.data_pos; // RULE_08 RULE_10
  assign tx_primary_data_neg        = tx_ff.data_neg; // RULE_08 RULE_10
  assign tx_primary_fwd_clock_pos   = tx_ff.clk_pos; // RULE_08
  assign tx_primary_fwd_clock_neg   = tx_ff.clk_neg; // RULE_08
  assign tx_redundant_data_pos      = tx_ff.data_pos; // RULE_10
  assign tx_redundant_data_neg      = tx_ff.data_neg; // RULE_10
  assign tx_redundant_fwd_clock_pos = tx_ff.clk_pos;
  assign tx_redundant_fwd_clock_neg = tx_ff.clk_neg;
  assign protection_switch_out      = switch_out_ff;
  assign reg_rdata                  = rdata_ff;
  assign tx_bit_taken               = taken_ff;
  assign rx_primary_bit             = rx_cap_ff[sls_pkg::PORT_PRIMARY];
  assign rx_redundant_bit           = rx_cap_ff[sls_pkg::PORT_REDUNDANT];
  assign rx_line_bit                = line_ff;

endmodule : sls_line_ports
`default_nettype wire

// file: sim/sls_line_sva.sv
// Purpose: port checks of the line-side serial ports
// Assumes: one mclk domain, synchronous reset
// Notes:   rx windows allow for synchroniser phase
`timescale 1ns/1ps
`default_nettype none
module sls_line_sva
(
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire logic                 rx_primary_clock_pos,
  input wire logic                 rx_redundant_clock_pos,
  input wire logic                 tx_primary_data_pos,
  input wire logic                 tx_primary_data_neg,
  input wire logic                 tx_primary_fwd_clock_pos,
  input wire logic                 tx_redundant_data_pos,
  input wire logic                 tx_redundant_fwd_clock_pos,
  input wire logic                 tx_bit_taken,
  input wire logic                 protection_internal_select,
  input wire logic                 protection_switch_out,
  input wire logic [15:0]          reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_rdata,
  input wire sls_pkg::sls_rx_bit_t rx_primary_bit,
  input wire sls_pkg::sls_rx_bit_t rx_redundant_bit
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire ctl_hit = reg_addr == sls_pkg::REG_LINE_CTRL2_ADDR;
  sequence s_launch; $rose(tx_primary_fwd_clock_pos); endsequence
  sequence s_taken; tx_bit_taken ##1 !tx_bit_taken; endsequence
  a_tx_pair_inv: assert property (tx_primary_data_neg == !tx_primary_data_pos)
    else $error("primary tx legs not complementary");
  a_red_copy: assert property ({tx_redundant_data_pos, tx_redundant_fwd_clock_pos} ==
    {tx_primary_data_pos, tx_primary_fwd_clock_pos}) else $error("redundant tx differs");
  a_pri_launch: assert property ($changed(tx_primary_data_pos) |-> s_launch)
    else $error("primary data moved off clock rise");
  a_red_launch: assert property ($changed(tx_redundant_data_pos) |->
    $rose(tx_redundant_fwd_clock_pos)) else $error("redundant data moved off clock rise");
  a_bit_taken: assert property (s_launch |-> s_taken)
    else $error("taken pulse missing after launch");
  a_pri_capture: assert property ($rose(rx_primary_clock_pos) |-> ##[2:4]
    rx_primary_bit.valid) else $error("primary rise not captured");
  a_red_capture: assert property ($rose(rx_redundant_clock_pos) |-> ##[2:4]
    rx_redundant_bit.valid) else $error("redundant rise not captured");
  a_ext_toggle: assert property (reg_wr && ctl_hit && reg_wdata[1] && !protection_internal_select
    |=> protection_switch_out != $past(protection_switch_out)) else $error("switch not toggled");
  a_unmapped_rd: assert property (reg_rd && !ctl_hit |=>
    reg_rdata == sls_pkg::REG_UNMAPPED_READ) else $error("unmapped read not zero");
endmodule : sls_line_sva
`default_nettype wire

// file: sim/sls_line_src.sv
// Purpose: far-side line source, one clock and data pair
// Assumes: 160 ns bit period, msb first
// Notes:   clock stands low between frames unless run stays high
`timescale 1ns/1ps
`default_nettype none
module sls_line_src
(
  input  wire logic       run,
  input  wire logic [7:0] pat,
  output logic            clk_p,
  output logic            clk_n,
  output logic            dat_p,
  output logic            dat_n
);
  // ==========================================================
  // frame generator; data moves at fall, steady across rise
  initial
  begin
    clk_p = 1'b0;
    dat_p = 1'b0;
    forever
    begin
      wait (run);
      for (int i = 7; i >= 0; i--)
      begin
        dat_p = pat[i];
        #80 clk_p = 1'b1;
        #80 clk_p = 1'b0;
      end
      // released line must not keep the last bit
      if (!run) dat_p = ~dat_p;
    end
  end
  assign clk_n = ~clk_p;
  assign dat_n = ~dat_p;
endmodule : sls_line_src
`default_nettype wire

// file: sim/sls_line_ports_bench.sv
// Purpose: self-checking bench of the line-side serial ports
// Assumes: line and reference clocks of 160 ns
// Notes:   reference stands in for the fast clock, runs free
`timescale 1ns/1ps
`default_nettype none
module sls_line_ports_bench;
  logic mclk, rst_n, rx_primary_clock_pos, rx_primary_clock_neg, rx_primary_data_pos;
  logic rx_primary_data_neg, rx_redundant_clock_pos, rx_redundant_clock_neg;
  logic rx_redundant_data_pos, rx_redundant_data_neg, tx_reference_clock_pos;
  logic tx_reference_clock_neg, tx_primary_data_pos, tx_primary_data_neg;
  logic tx_primary_fwd_clock_pos, tx_primary_fwd_clock_neg, tx_redundant_data_pos;
  logic tx_redundant_data_neg, tx_redundant_fwd_clock_pos, tx_redundant_fwd_clock_neg;
  logic protection_internal_select, protection_switch_out, reg_wr, reg_rd, tx_line_bit;
  logic tx_bit_taken, run_p, run_r, sw0;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, pat, p_byte, r_byte, l_byte;
  sls_pkg::sls_rx_bit_t rx_primary_bit, rx_redundant_bit, rx_line_bit;
  int error_cnt, n_tests, p_cnt, r_cnt, cyc;
  sls_line_ports i_sls_line_ports (.*);
  sls_line_src i_src_p (.run(run_p), .pat(pat), .clk_p(rx_primary_clock_pos),
    .clk_n(rx_primary_clock_neg), .dat_p(rx_primary_data_pos), .dat_n(rx_primary_data_neg));
  sls_line_src i_src_r (.run(run_r), .pat(pat), .clk_p(rx_redundant_clock_pos),
    .clk_n(rx_redundant_clock_neg), .dat_p(rx_redundant_data_pos), .dat_n(rx_redundant_data_neg));
  sls_line_src i_src_ref (.run(1'b1), .pat(8'h00), .clk_p(tx_reference_clock_pos),
    .clk_n(tx_reference_clock_neg), .dat_p(), .dat_n());
  // ==========================================================
  // clock, collectors, tasks
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial {cyc, p_cnt, r_cnt} = '0;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (rx_primary_bit.valid === 1'b1) {p_byte, p_cnt} <= {p_byte[6:0], rx_primary_bit[1], p_cnt + 1};
    if (rx_redundant_bit.valid === 1'b1) {r_byte, r_cnt} <= {r_byte[6:0], rx_redundant_bit[1], r_cnt + 1};
    if (rx_line_bit.valid === 1'b1) l_byte <= {l_byte[6:0], rx_line_bit.bit_value};
  end
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin error_cnt++; $display("[ERR] %s exp %h seen %h", nm, exp, seen); end
  endtask : chk
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk) #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge mclk) #1 reg_wr = 1'b0;
  endtask : wr
  task rd(input logic [15:0] a, input logic [7:0] e, input string nm);
    @(posedge mclk) #1 {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge mclk) #1 reg_rd = 1'b0;
    @(posedge mclk) #1 chk(nm, reg_rdata, e);
  endtask : rd
  task wt;
    int i;
    i = 0;
    do begin @(posedge mclk); #1; i++; end while (tx_bit_taken !== 1'b1 && i < 100);
  endtask : wt
  task tx(input logic [7:0] b, input int gap);
    int t0;
    wt();
    tx_line_bit = b[7];
    for (int i = 7; i >= 0; i--)
    begin
      wt();
      chk("tx_pri", {tx_primary_data_pos, tx_primary_data_neg, tx_primary_fwd_clock_pos,
        tx_primary_fwd_clock_neg, 4'h0}, {b[i], !b[i], 6'h20});
      chk("tx_red", {tx_redundant_data_pos, tx_redundant_data_neg, tx_redundant_fwd_clock_pos,
        tx_redundant_fwd_clock_neg, 4'h0}, {b[i], !b[i], 6'h20});
      if (i < 7) chk("tx_gap", 8'(cyc - t0), 8'(gap));
      t0 = cyc;
      if (i > 0) tx_line_bit = b[i - 1];
    end
  endtask : tx
  task rx(input logic sel, input logic [7:0] p);
    int n0;
    n0 = p_cnt + r_cnt;
    pat = p;
    @(posedge mclk) #1 {run_r, run_p} = {sel, !sel};
    @(posedge mclk) #1 {run_r, run_p} = 2'b00;
    repeat (300) if (p_cnt + r_cnt - n0 < 8) @(posedge mclk);
    repeat (12) @(posedge mclk);
  endtask : rx
  task results;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // ==========================================================
  // sequence and watchdog
  initial begin #200000; error_cnt++; results(); end
  initial
  begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, tx_line_bit, run_p, run_r, pat} = '0;
    {protection_internal_select, error_cnt, n_tests} = '0;
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk("tx_rst", {4'h0, tx_primary_data_pos, tx_primary_data_neg, tx_primary_fwd_clock_pos,
      tx_primary_fwd_clock_neg}, 8'h05);
    rd(16'h0131, 8'h00, "ctl_rst");
    wr(16'h0132, 8'h01);
    rd(16'h0131, 8'h00, "ctl_ign");
    rd(16'h0130, 8'h00, "unmapped");
    tx(8'hA5, 8);
    wr(16'h0131, 8'h01);
    rd(16'h0131, 8'h01, "ref_sel");
    tx(8'h3C, 32);
    rx(1'b0, 8'hA5);
    chk("rx_pri", p_byte, 8'hA5);
    chk("rx_red_idle", 8'(r_cnt), 8'h00);
    rx(1'b1, 8'h96);
    chk("rx_red", r_byte, 8'h96);
    chk("rx_pri_idle", 8'(p_cnt), 8'h08);
    chk("line_pri", l_byte, 8'hA5);
    sw0 = protection_switch_out;
    wr(16'h0131, 8'h03);
    chk("ext_sw", {7'h00, protection_switch_out}, {7'h00, !sw0});
    protection_internal_select = 1'b1;
    repeat (4) @(posedge mclk);
    rd(16'h0131, 8'h09, "mode_rd");
    wr(16'h0131, 8'h03);
    rd(16'h0131, 8'h0D, "swap_rd");
    chk("int_sw", {7'h00, protection_switch_out}, {7'h00, !sw0});
    rx(1'b1, 8'h5A);
    chk("line_red", l_byte, 8'h5A);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    rd(16'h0131, 8'h08, "ctl_rst2");
    results();
  end
endmodule : sls_line_ports_bench
bind sls_line_ports sls_line_sva i_sls_line_sva (.*);
`default_nettype wire
